/* File: core/pem_map.vh */
`ifndef PEM_MAP_VH
`define PEM_MAP_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PEM_SEL_OFFSET   12'h000
`define PEM_STAT_OFFSET  12'h004
`define PEM_SEL_RESET    16'h0000

// ----------------------------------------
// Field positions (low bit of each pair)
// ----------------------------------------
`define PEM_P15_LSB 14
`define PEM_P14_LSB 12
`define PEM_P13_LSB 10
`define PEM_P12_LSB 8
`define PEM_P11_LSB 6
`define PEM_P10_LSB 4
`define PEM_P9_LSB  2

// ----------------------------------------
// Selector codes
// ----------------------------------------
`define PEM_CODE_PORT 2'h0
`define PEM_CODE_F1   2'h1
`define PEM_CODE_F2   2'h2
`define PEM_CODE_F3   2'h3

// ----------------------------------------
// Pins taken over by the debug port (index 3..0 = pins 12..9)
// ----------------------------------------
`define PEM_JTAG_PINS 7'h0F

`endif

/* File: core/pem_pin_cell.v */
`timescale 1ns/1ps
`default_nettype none

// One pin: picks output value and enable from four sources by code
module pem_pin_cell
(
  // Selector
  input  wire [1:0] sel,
  input  wire [3:0] allowed,
  // Source values per code
  input  wire [3:0] src_out,
  input  wire [3:0] src_oe,
  // Result
  output reg        pin_out,
  output reg        pin_oe,
  output wire       legal
);

  // ----------------------------------------
  // Mux
  // ----------------------------------------
  // Prohibited code parks the pin undriven rather than guessing an owner
  assign legal = allowed[sel];

  always @*
  begin
    pin_out = src_out[sel] & legal;
    pin_oe  = src_oe[sel] & legal;
  end

endmodule
`default_nettype wire

/* File: core/pem_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "pem_map.vh"

module pem_top
#(
  parameter FLASH_VARIANT = 1
)
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Debug strap
  input  wire        debug_mode_pin,
  // Pad side, pins 15..9 at index 6..0
  input  wire [6:0]  pad_in,
  output reg  [6:0]  pad_out,
  output reg  [6:0]  pad_oe,
  // General port I/O
  input  wire [6:0]  gpio_out,
  input  wire [6:0]  gpio_oe,
  output reg  [6:0]  gpio_in,
  // Timer channels 3 and 4
  input  wire        timer_ch4_d_out,
  input  wire        timer_ch4_d_oe,
  input  wire        timer_ch4_c_out,
  input  wire        timer_ch4_c_oe,
  input  wire        timer_ch4_b_out,
  input  wire        timer_ch4_b_oe,
  input  wire        timer_ch4_a_out,
  input  wire        timer_ch4_a_oe,
  input  wire        timer_ch3_d_out,
  input  wire        timer_ch3_d_oe,
  input  wire        timer_ch3_c_out,
  input  wire        timer_ch3_c_oe,
  input  wire        timer_ch3_b_out,
  input  wire        timer_ch3_b_oe,
  output reg  [6:0]  timer_in,
  // DMA and interrupt unit
  input  wire        dma_ack1_out,
  input  wire        dma_ack0_out,
  input  wire        irq_request_out,
  output reg         manual_reset_in,
  // Serial units
  input  wire        serial3_tx_out,
  input  wire        serial2_tx_out,
  output reg         serial3_rx_in,
  input  wire        serial3_clk_out,
  input  wire        serial3_clk_oe,
  output reg         serial3_clk_in,
  // JTAG
  input  wire        jtag_tdo,
  output reg         jtag_tck,
  output reg         jtag_tdi,
  output reg         jtag_trst,
  output reg         jtag_active
);

  // ----------------------------------------
  // Register and decode
  // ----------------------------------------
  reg  [15:0] sel_r;
  reg         debug_r;
  wire [6:0]  legal;
  wire        hit_sel  = (paddr == `PEM_SEL_OFFSET);
  wire        hit_stat = (paddr == `PEM_STAT_OFFSET);
  wire        access   = psel & penable;
  wire        setup    = psel & ~penable;

  // ----------------------------------------
  // Debug strap
  // ----------------------------------------
  // Forced JTAG only on flash part; mask part ignores the strap
  // Limitation: the strap is a level, so a mid-run change re-routes pins 12..9 two clock edges later
  wire        force_jtag = debug_r & (FLASH_VARIANT != 0);

  // Strap sampled by clock, never through the async reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debug_r <= 1'b0;
    else
      debug_r <= debug_mode_pin;
  end

  // Selector register, writes take effect at the access edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_r <= `PEM_SEL_RESET;
    else if (access & pwrite & hit_sel)
      sel_r <= pwdata[15:0];
  end

  // ----------------------------------------
  // APB read path and response
  // ----------------------------------------
  // Read data formed in the setup cycle, so it stands with pready
  reg  [31:0] rdata_nxt;
  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (setup & ~pwrite & hit_sel)
      rdata_nxt = {16'h0000, sel_r};
    else if (setup & ~pwrite & hit_stat)
      rdata_nxt = {24'h000000, force_jtag, ~legal};
  end

  // APB answers in the first access cycle; unmapped gives slverr
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~(hit_sel | hit_stat);
      prdata  <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Per-pin selection tables
  // ----------------------------------------
  // Index 6 = pin 15 .. index 0 = pin 9; vectors are {code3,code2,code1,code0}
  wire [1:0] sel_p [0:6];
  wire [3:0] allow [0:6];
  wire [3:0] s_out [0:6];
  wire [3:0] s_oe  [0:6];
  wire [6:0] mux_out;
  wire [6:0] mux_oe;
  wire [6:0] timer_nxt;
  // Pins 12..9 belong to the debug port when it is forced
  localparam [6:0] JTAG_PINS = `PEM_JTAG_PINS;

  assign sel_p[6] = sel_r[`PEM_P15_LSB+1:`PEM_P15_LSB];
  assign sel_p[5] = sel_r[`PEM_P14_LSB+1:`PEM_P14_LSB];
  assign sel_p[4] = sel_r[`PEM_P13_LSB+1:`PEM_P13_LSB];
  assign sel_p[3] = sel_r[`PEM_P12_LSB+1:`PEM_P12_LSB];
  assign sel_p[2] = sel_r[`PEM_P11_LSB+1:`PEM_P11_LSB];
  assign sel_p[1] = sel_r[`PEM_P10_LSB+1:`PEM_P10_LSB];
  assign sel_p[0] = sel_r[`PEM_P9_LSB+1:`PEM_P9_LSB];

  // Allowed codes per pin
  assign allow[6] = 4'hF;
  assign allow[5] = 4'h7;
  assign allow[4] = 4'h7;
  assign allow[3] = 4'hB;
  assign allow[2] = 4'hB;
  assign allow[1] = 4'h7;
  assign allow[0] = 4'hB;

  // Pin 15: port, timer 4D, DMA ack1, irq request
  assign s_out[6] = {irq_request_out,
                     dma_ack1_out,
                     timer_ch4_d_out,
                     gpio_out[6]};
  assign s_oe[6]  = {1'b1,
                     1'b1,
                     timer_ch4_d_oe,
                     gpio_oe[6]};

  // Pin 14: port, timer 4C, DMA ack0
  assign s_out[5] = {1'b0,
                     dma_ack0_out,
                     timer_ch4_c_out,
                     gpio_out[5]};
  assign s_oe[5]  = {1'b0,
                     1'b1,
                     timer_ch4_c_oe,
                     gpio_oe[5]};

  // Pin 13: port, timer 4B, manual reset input (not driven)
  assign s_out[4] = {1'b0,
                     1'b0,
                     timer_ch4_b_out,
                     gpio_out[4]};
  assign s_oe[4]  = {1'b0,
                     1'b0,
                     timer_ch4_b_oe,
                     gpio_oe[4]};

  // Pin 12: port, timer 4A, serial3 transmit
  assign s_out[3] = {serial3_tx_out,
                     1'b0,
                     timer_ch4_a_out,
                     gpio_out[3]};
  assign s_oe[3]  = {1'b1,
                     1'b0,
                     timer_ch4_a_oe,
                     gpio_oe[3]};

  // Pin 11: port, timer 3D, serial3 receive (input)
  assign s_out[2] = {1'b0,
                     1'b0,
                     timer_ch3_d_out,
                     gpio_out[2]};
  assign s_oe[2]  = {1'b0,
                     1'b0,
                     timer_ch3_d_oe,
                     gpio_oe[2]};

  // Pin 10: port, timer 3C, serial2 transmit
  assign s_out[1] = {1'b0,
                     serial2_tx_out,
                     timer_ch3_c_out,
                     gpio_out[1]};
  assign s_oe[1]  = {1'b0,
                     1'b1,
                     timer_ch3_c_oe,
                     gpio_oe[1]};

  // Pin 9: port, timer 3B, serial3 clock
  assign s_out[0] = {serial3_clk_out,
                     1'b0,
                     timer_ch3_b_out,
                     gpio_out[0]};
  assign s_oe[0]  = {serial3_clk_oe,
                     1'b0,
                     timer_ch3_b_oe,
                     gpio_oe[0]};

  // One mux cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_pin
      pem_pin_cell u_cell
      (
        .sel     (sel_p[gi]),
        .allowed (allow[gi]),
        .src_out (s_out[gi]),
        .src_oe  (s_oe[gi]),
        .pin_out (mux_out[gi]),
        .pin_oe  (mux_oe[gi]),
        .legal   (legal[gi])
      );
      // Timer sees the pad only on code 01 and not while JTAG owns the pin
      assign timer_nxt[gi] = (sel_p[gi] == `PEM_CODE_F1) & ~(force_jtag & JTAG_PINS[gi]) & pad_in[gi];
    end
  endgenerate

  // ----------------------------------------
  // Pad drive with JTAG override
  // ----------------------------------------
  // Next pad state: selector mux first, then the debug override on pins 12..9
  reg  [6:0] pad_out_nxt;
  reg  [6:0] pad_oe_nxt;
  always @*
  begin
    pad_out_nxt = mux_out;
    pad_oe_nxt  = mux_oe;
    if (force_jtag)
    begin
      pad_oe_nxt[3]  = 1'b0;
      pad_out_nxt[3] = 1'b0;
      pad_oe_nxt[2]  = 1'b1;
      pad_out_nxt[2] = jtag_tdo;
      pad_oe_nxt[1]  = 1'b0;
      pad_out_nxt[1] = 1'b0;
      pad_oe_nxt[0]  = 1'b0;
      pad_out_nxt[0] = 1'b0;
    end
  end

  // Registered outputs add one cycle of latency from selector to pad
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out     <= 7'h00;
      pad_oe      <= 7'h00;
      jtag_active <= 1'b0;
    end
    else
    begin
      pad_out     <= pad_out_nxt;
      pad_oe      <= pad_oe_nxt;
      jtag_active <= force_jtag;
    end
  end

  // ----------------------------------------
  // Inputs routed back to peripherals
  // ----------------------------------------
  // Unselected peripheral inputs read as zero; JTAG pins hide the pad from the timer and serial3 inputs, not from gpio_in
  reg        manual_reset_in_nxt;
  reg        rx3_nxt;
  reg        clk3_nxt;
  reg  [2:0] jtag_in_nxt;
  always @*
  begin
    manual_reset_in_nxt    = (sel_p[4] == `PEM_CODE_F2) & pad_in[4];
    rx3_nxt     = 1'b0;
    clk3_nxt    = 1'b0;
    jtag_in_nxt = 3'h0;
    if (force_jtag)
    begin
      jtag_in_nxt = {pad_in[3], pad_in[1], pad_in[0]};
    end
    else
    begin
      rx3_nxt  = (sel_p[2] == `PEM_CODE_F3) & pad_in[2];
      clk3_nxt = (sel_p[0] == `PEM_CODE_F3) & pad_in[0];
    end
  end

  // Registered so every peripheral input changes only at a clock edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_in         <= 7'h00;
      timer_in        <= 7'h00;
      manual_reset_in <= 1'b0;
      serial3_rx_in   <= 1'b0;
      serial3_clk_in  <= 1'b0;
      jtag_tck        <= 1'b0;
      jtag_tdi        <= 1'b0;
      jtag_trst       <= 1'b0;
    end
    else
    begin
      gpio_in         <= pad_in;
      timer_in        <= timer_nxt;
      manual_reset_in <= manual_reset_in_nxt;
      serial3_rx_in   <= rx3_nxt;
      serial3_clk_in  <= clk3_nxt;
      jtag_tck        <= jtag_in_nxt[2];
      jtag_tdi        <= jtag_in_nxt[1];
      jtag_trst       <= jtag_in_nxt[0];
    end
  end

endmodule
`default_nettype wire

/* File: dv/pem_periph.sv */
`timescale 1ns/1ps
`default_nettype none
// Timer, DMA, interrupt and serial drives toward the mux
module pem_periph
(
  // Level from the bench
  input  wire       lvl,
  // Drives
  output wire [6:0] t_o,
  output wire [6:0] t_e,
  output wire [5:0] p_o,
  output wire       s3c_oe,
  output wire       tdo
);
  // Timers opposite the rest, so a wrong source shows on a pad
  assign t_o = {7{~lvl}};
  assign t_e = 7'h7F;
  assign p_o = {6{lvl}};
  assign s3c_oe = 1'b1;
  assign tdo = lvl;
endmodule
`default_nettype wire

/* File: dv/pem_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Pad routing checker, keeps a shadow copy of the selector
module pem_chk
#(
  parameter FLASH_VARIANT = 1
)
(
  // Clock, reset and bus
  input wire        pclk,
  input wire        presetn,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Pads and sources
  input wire        debug_mode_pin,
  input wire [6:0]  pad_in,
  input wire [6:0]  pad_out,
  input wire [6:0]  pad_oe,
  input wire        irq_request_out,
  input wire        serial3_tx_out,
  input wire        serial2_tx_out,
  input wire        timer_ch3_b_out,
  input wire        timer_ch3_b_oe,
  input wire        jtag_tdo,
  input wire        jtag_tck,
  input wire        manual_reset_in,
  input wire        serial3_rx_in
);
  reg [15:0] sel_h;
  reg [1:0]  live;
  // Shadow; pads trail the strap by two edges, so hold off three
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_h <= 16'h0000;
      live <= 2'h0;
    end
    else
    begin
      if (pready && pwrite && paddr == 12'h000)
        sel_h <= pwdata[15:0];
      if (live != 2'h3)
        live <= live + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || live != 2'h3);
  property p_p15; $past(sel_h[15:14]) == 2'h3 |-> pad_oe[6] && pad_out[6] == $past(irq_request_out); endproperty
  a_p15: assert property (p_p15) else $error("pin15 route");
  property p_p13; $past(sel_h[11:10]) == 2'h2 |-> !pad_oe[4] && manual_reset_in == $past(pad_in[4]); endproperty
  a_p13: assert property (p_p13) else $error("pin13 route");
  property p_p12;
    !$past(debug_mode_pin, 2) && $past(sel_h[9:8]) == 2'h3 |->
      pad_oe[3] && pad_out[3] == $past(serial3_tx_out);
  endproperty
  a_p12: assert property (p_p12) else $error("pin12 route");
  property p_p11;
    !$past(debug_mode_pin, 2) && $past(sel_h[7:6]) == 2'h3 |->
      !pad_oe[2] && serial3_rx_in == $past(pad_in[2]);
  endproperty
  a_p11: assert property (p_p11) else $error("pin11 route");
  property p_p10;
    !$past(debug_mode_pin, 2) && $past(sel_h[5:4]) == 2'h2 |->
      pad_oe[1] && pad_out[1] == $past(serial2_tx_out);
  endproperty
  a_p10: assert property (p_p10) else $error("pin10 route");
  property p_p9;
    !$past(debug_mode_pin, 2) && $past(sel_h[3:2]) == 2'h1 |->
      pad_oe[0] == $past(timer_ch3_b_oe) && pad_out[0] == $past(timer_ch3_b_out);
  endproperty
  a_p9: assert property (p_p9) else $error("pin9 route");
  property p_tck;
    FLASH_VARIANT != 0 && $past(debug_mode_pin, 2) |->
      pad_oe[3:0] == 4'h4 && jtag_tck == $past(pad_in[3]);
  endproperty
  a_tck: assert property (p_tck) else $error("debug inputs");
  property p_tdo; FLASH_VARIANT != 0 && $past(debug_mode_pin, 2) |-> pad_out[2] == $past(jtag_tdo); endproperty
  a_tdo: assert property (p_tdo) else $error("debug output");
endmodule
bind pem_top pem_chk #(.FLASH_VARIANT(FLASH_VARIANT)) pem_chk_inst (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .debug_mode_pin(debug_mode_pin), .pad_in(pad_in), .pad_out(pad_out),
  .pad_oe(pad_oe), .irq_request_out(irq_request_out), .serial3_tx_out(serial3_tx_out), .serial2_tx_out(serial2_tx_out),
  .timer_ch3_b_out(timer_ch3_b_out), .timer_ch3_b_oe(timer_ch3_b_oe), .jtag_tdo(jtag_tdo), .jtag_tck(jtag_tck),
  .manual_reset_in(manual_reset_in), .serial3_rx_in(serial3_rx_in));
`default_nettype wire

/* File: dv/pem_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pem_top_tb;
  localparam [27:0] MSK = {7'h49, 7'h62, 7'h7F, 7'h7F};
  localparam [27:0] PRO = {7'h32, 7'h0D, 7'h00, 7'h00};
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dbg = 0, lvl = 0, er;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, rd;
  reg  [6:0]  pad_in = 7'h3D;
  integer     errors = 0, n_tests = 0, cyc = 0, c, l;
  wire [31:0] prdata;
  wire [6:0]  pad_out, pad_oe, gpio_in, timer_in, t_o, t_e;
  wire [5:0]  p_o;
  wire        pready, pslverr, s3c_oe, tdo, mrin, rxin, s3cin, tck, tdi, trst, jact;
  pem_periph pem_periph_inst (.lvl(lvl), .t_o(t_o), .t_e(t_e), .p_o(p_o), .s3c_oe(s3c_oe), .tdo(tdo));
  pem_top pem_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_mode_pin(dbg),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .gpio_out(7'h55), .gpio_oe(7'h7F), .gpio_in(gpio_in),
    .timer_ch4_d_out(t_o[6]), .timer_ch4_d_oe(t_e[6]), .timer_ch4_c_out(t_o[5]), .timer_ch4_c_oe(t_e[5]),
    .timer_ch4_b_out(t_o[4]), .timer_ch4_b_oe(t_e[4]), .timer_ch4_a_out(t_o[3]), .timer_ch4_a_oe(t_e[3]),
    .timer_ch3_d_out(t_o[2]), .timer_ch3_d_oe(t_e[2]), .timer_ch3_c_out(t_o[1]), .timer_ch3_c_oe(t_e[1]),
    .timer_ch3_b_out(t_o[0]), .timer_ch3_b_oe(t_e[0]), .timer_in(timer_in), .dma_ack1_out(p_o[5]),
    .dma_ack0_out(p_o[4]), .irq_request_out(p_o[3]), .manual_reset_in(mrin), .serial3_tx_out(p_o[2]),
    .serial2_tx_out(p_o[1]), .serial3_rx_in(rxin), .serial3_clk_out(p_o[0]), .serial3_clk_oe(s3c_oe),
    .serial3_clk_in(s3cin), .jtag_tdo(tdo), .jtag_tck(tck), .jtag_tdi(tdi), .jtag_trst(trst), .jtag_active(jact));
  // 20 MHz clock
  always #25 pclk = ~pclk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Hang guard, far above the roughly 115 cycles needed
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  // Every code on every pin at once, both source levels
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 0);
    for (l = 0; l < 2; l = l + 1)
      for (c = 0; c < 4; c = c + 1)
      begin
        lvl <= l[0];
        apb(1, 12'h000, 32'hFFFF0003 | (c * 32'h5554));
        apb(0, 12'h000, 0);
        chk(rd, 3 + c * 32'h5554);
        apb(0, 12'h004, 0);
        chk(rd, PRO[c*7 +: 7]);
        chk(pad_oe, MSK[c*7 +: 7]);
        chk(pad_out, (c == 0) ? 7'h55 : MSK[c*7 +: 7] & {7{(c == 1) ^ l[0]}});
        chk({timer_in, gpio_in}, {(c == 1) ? 7'h3D : 7'h00, 7'h3D});
        chk({mrin, rxin, s3cin}, {c == 2, c == 3, c == 3});
      end
    $display("codes done");
    apb(1, 12'h008, 32'hFFFF);
    chk(er, 1);
    apb(1, 12'h004, 32'hFF);
    apb(0, 12'h000, 0);
    chk(rd, 32'hFFFF);
    $display("refusals done");
    dbg <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(pad_oe, 7'h44);
    chk({pad_out[2], tck, tdi, trst, jact}, 5'h1B);
    apb(0, 12'h004, 0);
    chk(rd, 32'hB2);
    dbg <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 0);
    chk(pad_oe, 7'h7F);
    $display("debug and reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
